//--- rtl/nfc_params.svh
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH

// ----------------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------------
`define NFC_CMD_READ_A      8'h00
`define NFC_CMD_READ_B      8'h01
`define NFC_CMD_COPY_MP     8'h03
`define NFC_CMD_PROG_END_MP 8'h11
`define NFC_CMD_PROG_END    8'h10
`define NFC_CMD_READ_C      8'h50
`define NFC_CMD_READ_ID     8'h90
`define NFC_CMD_RESET       8'hff
`define NFC_CMD_PROG        8'h80
`define NFC_CMD_COPY        8'h8a
`define NFC_CMD_ERASE       8'h60
`define NFC_CMD_ERASE_GO    8'hd0
`define NFC_CMD_STATUS      8'h70
`define NFC_CMD_STATUS_MP   8'h71

// ----------------------------------------------------------------------------
// op field values of the user request
// ----------------------------------------------------------------------------
`define NFC_OP_CMD          3'h0
`define NFC_OP_ADDR4        3'h1
`define NFC_OP_ADDR3        3'h2
`define NFC_OP_WDATA        3'h3
`define NFC_OP_RDATA        3'h4

// ----------------------------------------------------------------------------
// geometry and timing
// ----------------------------------------------------------------------------
`define NFC_PAGES           131072
`define NFC_COLUMNS         528
`define NFC_SPARE_START     512
`define NFC_BLOCKS          4096
`define NFC_PLANES          4
`define NFC_ADDR_BITS       26
`define NFC_PHASE_NS        32
`define NFC_CLK_NS          4
`define NFC_PHASE_CYC       ((`NFC_PHASE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

//--- rtl/nfc_pkg.sv
package nfc_pkg;

   // strobe sequencer states
   typedef enum logic [4:0]
   {
      NFC_IDLE  = 5'b00001,
      NFC_LOW   = 5'b00010,
      NFC_HIGH  = 5'b00100,
      NFC_HOLD  = 5'b01000,
      NFC_DONE  = 5'b10000
   } nfc_state_type;

endpackage : nfc_pkg

//--- rtl/nfc_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "nfc_params.svh"

// ----------------------------------------------------------------------------
// phase timer: pulses done once a loaded phase has lasted its full length
// ----------------------------------------------------------------------------
module nfc_phase_timer
(
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic clkEn,
   input  wire logic start,
   output logic      done
);

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       done_nxt;

   // count down, done on the last cycle of the phase
   always_comb
   begin
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      if (start)
         cnt_nxt = 8'(`NFC_PHASE_CYC - 1);
      else if (cnt_r != 8'h00)
      begin
         cnt_nxt = cnt_r - 8'h01;
         done_nxt = (cnt_r == 8'h01);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         cnt_r <= 8'h00;
         done  <= 1'b0;
      end
      else if (clkEn)
      begin
         cnt_r <= cnt_nxt;
         done  <= done_nxt;
      end
   end

endmodule : nfc_phase_timer

`default_nettype wire

//--- rtl/nfc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "nfc_params.svh"

// ----------------------------------------------------------------------------
// host-side controller: turns user requests into flash bus cycles
// ----------------------------------------------------------------------------

module nfc_host
   import nfc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   input  wire logic        reqValid,
   input  wire logic [2:0]  reqOp,
   input  wire logic [25:0] reqData,
   output logic             reqReady,
   output logic             rspValid,
   output logic [15:0]      rspData,
   output logic             rspRefused,
   output logic             flashBusy,
   output logic             chipEn_n,
   output logic             cmdLatch,
   output logic             addrLatch,
   output logic             writeStrobe_n,
   output logic             read_strobe_n,
   output logic [15:0]      ioOut,
   output logic             ioOe,
   input  wire logic [15:0] ioIn,
   input  wire logic        readyBusy
);

   nfc_state_type state_r;
   nfc_state_type state_nxt;
   logic [2:0]    op_r;
   logic [2:0]    op_nxt;
   logic [25:0]   data_r;
   logic [25:0]   data_nxt;
   logic [1:0]    left_r;
   logic [1:0]    left_nxt;
   logic          reqReady_nxt;
   logic          rspValid_nxt;
   logic [15:0]   rspData_nxt;
   logic          rspRefused_nxt;
   logic          chipEn_n_nxt;
   logic          cmdLatch_nxt;
   logic          addrLatch_nxt;
   logic          writeStrobe_n_nxt;
   logic          read_strobe_n_nxt;
   logic [15:0]   ioOut_nxt;
   logic          ioOe_nxt;
   logic          tmrStart;
   logic          tmrDone;
   logic          allowed;

   // every strobe phase lasts the same time, one timer serves them all
   nfc_phase_timer u_timer
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .clkEn   (clkEn),
      .start   (tmrStart),
      .done    (tmrDone)
   );

   // -------------------------------------------------------------------------
   // request screening
   // -------------------------------------------------------------------------

   // only defined codes pass; while busy only reset and status reads
   function automatic logic cmd_ok(input logic [7:0] c, input logic busy);
      logic def;
      def = (c == `NFC_CMD_READ_A)   || (c == `NFC_CMD_READ_B)  ||
            (c == `NFC_CMD_COPY_MP)  || (c == `NFC_CMD_PROG_END_MP) ||
            (c == `NFC_CMD_PROG_END) || (c == `NFC_CMD_READ_C)  ||
            (c == `NFC_CMD_READ_ID)  || (c == `NFC_CMD_RESET)   ||
            (c == `NFC_CMD_PROG)     || (c == `NFC_CMD_COPY)    ||
            (c == `NFC_CMD_ERASE)    || (c == `NFC_CMD_ERASE_GO) ||
            (c == `NFC_CMD_STATUS)   || (c == `NFC_CMD_STATUS_MP);
      if (busy)
         cmd_ok = (c == `NFC_CMD_RESET) || (c == `NFC_CMD_STATUS) ||
                  (c == `NFC_CMD_STATUS_MP);
      else
         cmd_ok = def;
   endfunction : cmd_ok

   // a busy device may be polled for status or reset, nothing else goes out
   always_comb
   begin
      if (reqOp == `NFC_OP_CMD)
         allowed = cmd_ok(reqData[7:0], !readyBusy);
      else if (reqOp == `NFC_OP_RDATA)
         allowed = 1'b1;                                             // status bytes read while busy
      else if (reqOp == `NFC_OP_ADDR4 || reqOp == `NFC_OP_ADDR3 || reqOp == `NFC_OP_WDATA)
         allowed = readyBusy;
      else
         allowed = 1'b0;
   end

   // -------------------------------------------------------------------------
   // bus cycle sequencer
   // -------------------------------------------------------------------------

   // one request = one or more strobe cycles; low phase, high phase, hold
   always_comb
   begin
      state_nxt         = state_r;
      op_nxt            = op_r;
      data_nxt          = data_r;
      left_nxt          = left_r;
      reqReady_nxt      = reqReady;
      rspValid_nxt      = 1'b0;
      rspData_nxt       = rspData;
      rspRefused_nxt    = 1'b0;
      chipEn_n_nxt      = chipEn_n;
      cmdLatch_nxt      = cmdLatch;
      addrLatch_nxt     = addrLatch;
      writeStrobe_n_nxt = writeStrobe_n;
      read_strobe_n_nxt = read_strobe_n;
      ioOut_nxt         = ioOut;
      ioOe_nxt          = ioOe;
      tmrStart          = 1'b0;
      case (state_r)
         NFC_IDLE:
         begin
            if (reqValid && reqReady)
            begin
               if (!allowed)
               begin
                  rspRefused_nxt = 1'b1;                             // refused, nothing driven
               end
               else
               begin
                  reqReady_nxt  = 1'b0;
                  op_nxt        = reqOp;
                  data_nxt      = reqData;
                  chipEn_n_nxt  = 1'b0;
                  cmdLatch_nxt  = (reqOp == `NFC_OP_CMD);
                  addrLatch_nxt = (reqOp == `NFC_OP_ADDR4) ||
                                  (reqOp == `NFC_OP_ADDR3);
                  // column byte first, then row bytes; erase skips column
                  if (reqOp == `NFC_OP_ADDR4)
                  begin
                     left_nxt  = 2'h3;
                     ioOut_nxt = {8'h00, reqData[7:0]};
                  end
                  else if (reqOp == `NFC_OP_ADDR3)
                  begin
                     left_nxt  = 2'h2;
                     ioOut_nxt = {8'h00, reqData[16:9]};
                     data_nxt  = {8'h00, reqData[25:9], 1'b0};
                  end
                  else
                  begin
                     left_nxt  = 2'h0;
                     ioOut_nxt = reqData[15:0];
                  end
                  if (reqOp == `NFC_OP_RDATA)
                  begin
                     read_strobe_n_nxt = 1'b0;
                     ioOe_nxt          = 1'b0;
                  end
                  else
                  begin
                     writeStrobe_n_nxt = 1'b0;
                     ioOe_nxt          = 1'b1;
                  end
                  tmrStart  = 1'b1;
                  state_nxt = NFC_LOW;
               end
            end
         end
         NFC_LOW:
         begin
            if (tmrDone)
            begin
               // rising write strobe is where the device latches the bus
               writeStrobe_n_nxt = 1'b1;
               if (op_r == `NFC_OP_RDATA)
               begin
                  rspData_nxt       = ioIn;                          // sampled at end of low phase
                  read_strobe_n_nxt = 1'b1;
               end
               tmrStart  = 1'b1;
               state_nxt = NFC_HIGH;
            end
         end
         NFC_HIGH:
         begin
            if (tmrDone)
            begin
               if (left_r != 2'h0)
               begin
                  // next row byte; two byte shifts leave the top row bit at bit 9
                  left_nxt          = left_r - 2'h1;
                  data_nxt          = {8'h00, data_r[25:8]};
                  ioOut_nxt         = (left_r == 2'h1) ? {15'h0000, data_r[9]}
                                                       : {8'h00, data_r[16:9]};
                  writeStrobe_n_nxt = 1'b0;
                  tmrStart          = 1'b1;
                  state_nxt         = NFC_LOW;
               end
               else
               begin
                  state_nxt = NFC_HOLD;
               end
            end
         end
         NFC_HOLD:
         begin
            // latch enables drop after the last strobe, bus released
            cmdLatch_nxt  = 1'b0;
            addrLatch_nxt = 1'b0;
            ioOe_nxt      = 1'b0;
            state_nxt     = NFC_DONE;
         end
         NFC_DONE:
         begin
            rspValid_nxt = 1'b1;
            reqReady_nxt = 1'b1;
            state_nxt    = NFC_IDLE;
         end
         default:
         begin
            state_nxt = NFC_IDLE;
         end
      endcase
   end

   // registers; chip stays selected between requests so sequences hold together
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         state_r       <= NFC_IDLE;
         op_r          <= 3'h0;
         data_r        <= 26'h0000000;
         left_r        <= 2'h0;
         reqReady      <= 1'b0;
         rspValid      <= 1'b0;
         rspData       <= 16'h0000;
         rspRefused    <= 1'b0;
         flashBusy     <= 1'b0;
         chipEn_n      <= 1'b1;
         cmdLatch      <= 1'b0;
         addrLatch     <= 1'b0;
         writeStrobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         ioOut         <= 16'h0000;
         ioOe          <= 1'b0;
      end
      else if (clkEn)
      begin
         state_r       <= state_nxt;
         op_r          <= op_nxt;
         data_r        <= data_nxt;
         left_r        <= left_nxt;
         reqReady      <= (state_r == NFC_IDLE) ? reqReady_nxt | !reqReady : reqReady_nxt;
         rspValid      <= rspValid_nxt;
         rspData       <= rspData_nxt;
         rspRefused    <= rspRefused_nxt;
         flashBusy     <= !readyBusy;
         chipEn_n      <= chipEn_n_nxt;
         cmdLatch      <= cmdLatch_nxt;
         addrLatch     <= addrLatch_nxt;
         writeStrobe_n <= writeStrobe_n_nxt;
         read_strobe_n <= read_strobe_n_nxt;
         ioOut         <= ioOut_nxt;
         ioOe          <= ioOe_nxt;
      end
   end

endmodule : nfc_host

`default_nettype wire

//--- sim/nfc_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// host pin checker
// ------
module nfc_host_properties
(
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        clkEn,
   input wire logic        reqValid,
   input wire logic [2:0]  reqOp,
   input wire logic [25:0] reqData,
   input wire logic        reqReady,
   input wire logic        rspValid,
   input wire logic        rspRefused,
   input wire logic        flashBusy,
   input wire logic        chipEn_n,
   input wire logic        cmdLatch,
   input wire logic        addrLatch,
   input wire logic        writeStrobe_n,
   input wire logic        read_strobe_n,
   input wire logic [15:0] ioOut,
   input wire logic        ioOe,
   input wire logic        readyBusy
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   logic take;
   logic known;
   logic safe;
   // taken request, defined code, code or data read allowed while busy
   assign take = reqValid && reqReady && clkEn;
   assign known = reqData[7:0] inside {8'h00, 8'h01, 8'h03, 8'h10, 8'h11, 8'h50,
      8'h60, 8'h70, 8'h71, 8'h80, 8'h8a, 8'h90, 8'hd0, 8'hff};
   assign safe = reqOp == 3'h4 || (reqOp == 3'h0 && reqData[7:0] inside {8'h70, 8'h71, 8'hff});
   a_reset_quiet:
   assert property (disable iff (1'b0) !nrst |=> chipEn_n && writeStrobe_n && read_strobe_n
      && !ioOe && !cmdLatch && !addrLatch && !reqReady) else $error("pins active in reset");
   a_latch_apart:
   assert property (!(cmdLatch && addrLatch)) else $error("both latch enables high");
   a_strobe_owned:
   assert property (!writeStrobe_n |-> !chipEn_n && ioOe && read_strobe_n)
      else $error("write strobe without select or drive");
   a_write_width:
   assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*8]) else $error("short strobe");
   a_hold_stable:
   assert property (!writeStrobe_n |=> $stable(ioOut) && $stable(cmdLatch) && $stable(addrLatch))
      else $error("bus moved under strobe");
   a_read_quiet:
   assert property ($fell(read_strobe_n) |-> !ioOe && !cmdLatch && !addrLatch && !chipEn_n)
      else $error("read strobe while driving");
   a_refuse_busy:
   assert property (take && !readyBusy && !safe |=> rspRefused) else $error("busy not refused");
   a_refuse_undef:
   assert property (take && reqOp == 3'h0 && !known |=> rspRefused) else $error("bad code sent");
   a_cmd_answer:
   assert property (take && reqOp == 3'h0 && known && readyBusy |=> !rspRefused ##[14:22] rspValid)
      else $error("command not completed");
   a_busy_follow:
   assert property ($fell(readyBusy) |=> flashBusy) else $error("busy not seen");
endmodule : nfc_host_properties
bind nfc_host nfc_host_properties chk (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
   .reqValid(reqValid), .reqOp(reqOp), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
   .rspRefused(rspRefused), .flashBusy(flashBusy), .chipEn_n(chipEn_n), .cmdLatch(cmdLatch),
   .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
   .ioOut(ioOut), .ioOe(ioOe), .readyBusy(readyBusy));
`default_nettype wire

//--- sim/nfc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// flash device model
// ------
module nfc_flash_model
#(
   parameter int BUSY_NS = 2000
)
(
   input  wire logic        chipEn_n,
   input  wire logic        cmdLatch,
   input  wire logic        addrLatch,
   input  wire logic        writeStrobe_n,
   input  wire logic        read_strobe_n,
   input  wire logic [15:0] ioOut,
   output logic [15:0]      ioIn,
   output logic             readyBusy
);
   logic [7:0]  cmd = 8'hff; // copy-back moves no data over the bus
   logic [7:0]  addrB [4]; // plane bits travel in the row bytes
   logic [15:0] wData;
   logic        half = 1'b0;
   logic [8:0]  col = 9'h0; // 9-bit column pointer, wraps after column 511
   int          nAddr = 0;
   initial readyBusy = 1'b1;
   initial ioIn = 16'h5a5a;
   // every address and write data cycle is taken at the write strobe rise; commands only when ready or 70, 71, ff
   always @(posedge writeStrobe_n)
      if (chipEn_n !== 1'b0)
         ;
      else if (cmdLatch)
      begin
         if (readyBusy || ioOut[7:0] inside {8'h70, 8'h71, 8'hff})
         begin
            cmd = ioOut[7:0];
            nAddr = 0;
            if (ioOut[7:0] inside {8'h00, 8'h01})
               half = ioOut[0];
            if (ioOut[7:0] inside {8'h10, 8'hd0})
            begin
               readyBusy = 1'b0;
               readyBusy <= #(BUSY_NS) 1'b1;
            end
         end
      end
      else if (addrLatch)
      begin
         if (nAddr < ((cmd == 8'h60) ? 3 : 4))
            addrB[nAddr] = ioOut[7:0];
         if (nAddr == 0 && cmd != 8'h60)
         begin
            col = {half, ioOut[7:0]};
            half = 1'b0; // later accesses start in the first half
         end
         nAddr = nAddr + 1;
      end
      else
      begin
         wData = ioOut;
         nAddr = 0;
      end
   // data or status on each read strobe fall
   always @(negedge read_strobe_n)
      if (chipEn_n === 1'b0)
      begin
         if (cmd inside {8'h70, 8'h71}) // all planes pass, bit 7 shows ready here
            ioIn = {8'h00, readyBusy ? 8'he0 : 8'h60};
         else
            ioIn = {7'h00, col};
         col = col + 9'h1;
         nAddr = 0;
      end
   // no pull on the bus, so a released line shows the inverse
   always @(posedge read_strobe_n)
      ioIn <= #6 ~ioIn;
endmodule : nfc_flash_model
`default_nettype wire

//--- sim/nfc_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// host controller bench
// ------
module nfc_host_tb;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        clkEn = 1'b1;
   logic        reqValid = 1'b0;
   logic [2:0]  reqOp = 3'h0;
   logic [25:0] reqData = 26'h0;
   logic        reqReady, rspValid, rspRefused, flashBusy, chipEn_n, cmdLatch, addrLatch;
   logic        writeStrobe_n, read_strobe_n, ioOe, readyBusy, rf;
   logic [15:0] rspData, ioOut, ioIn, rd, w;
   logic [25:0] a;
   logic [31:0] ab;
   logic [7:0]  code;
   logic [7:0]  codes [14] = '{8'h00, 8'h01, 8'h03, 8'h11, 8'h50, 8'h90, 8'hff, 8'h80,
      8'h8a, 8'h60, 8'h70, 8'h71, 8'h10, 8'hd0};
   int          seed, n_mismatch = 0, n_checks = 0;
   always #2 clk_sys = ~clk_sys;
   nfc_host uut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .reqValid(reqValid),
      .reqOp(reqOp), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .rspRefused(rspRefused), .flashBusy(flashBusy), .chipEn_n(chipEn_n),
      .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n),
      .read_strobe_n(read_strobe_n), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
      .readyBusy(readyBusy));
   nfc_flash_model dev (.chipEn_n(chipEn_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
      .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n), .ioOut(ioOut),
      .ioIn(ioIn), .readyBusy(readyBusy));
   // bytes the device should see for a full address
   function automatic logic [31:0] addr_bytes(input logic [25:0] x);
      return {x[7:0], x[16:9], x[24:17], 7'h00, x[25]};
   endfunction : addr_bytes
   // read word expected from a start column plus k strobes
   function automatic logic [31:0] col_word(input logic h, input logic [7:0] c, input int k);
      return {23'h0, {h, c} + 9'(k)};
   endfunction : col_word
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one request at a falling edge; waits are bounded
   task automatic op(input logic [2:0] o, input logic [25:0] d, input logic er);
      int i;
      i = 0;
      while (reqReady !== 1'b1 && i < 400)
      begin
         @(negedge clk_sys);
         i++;
      end
      reqValid = 1'b1;
      reqOp = o;
      reqData = d;
      @(negedge clk_sys);
      reqValid = 1'b0;
      while (rspValid !== 1'b1 && rspRefused !== 1'b1 && i < 400)
      begin
         @(negedge clk_sys);
         i++;
      end
      if (i >= 400)
      begin
         n_mismatch++;
         wrap_up;
      end
      rf = rspRefused;
      rd = rspData;
      @(negedge clk_sys);
      chk({31'h0, rf}, {31'h0, er});
   endtask : op
   task automatic wait_ready;
      int i;
      for (i = 0; readyBusy !== 1'b1 && i < 1000; i++)
         @(negedge clk_sys);
      if (i >= 1000)
      begin
         n_mismatch++;
         wrap_up;
      end
      repeat (2) @(negedge clk_sys);
   endtask : wait_ready
   // main sequence
   initial
   begin
      seed = 97032;
      repeat (4) @(negedge clk_sys);
      chk({28'h0, chipEn_n, writeStrobe_n, read_strobe_n, ioOe}, 32'he);
      nrst = 1'b1;
      @(negedge clk_sys);
      a = 26'($random(seed));
      op(3'h0, 26'h80, 1'b0);
      op(3'h1, a, 1'b0);
      repeat (3)
      begin
         w = 16'($random(seed));
         op(3'h3, {10'h0, w}, 1'b0);
      end
      chk({16'h0, dev.wData}, {16'h0, w});
      chk({dev.addrB[0], dev.addrB[1], dev.addrB[2], dev.addrB[3]}, addr_bytes(a));
      op(3'h0, 26'h10, 1'b0);
      op(3'h0, 26'h80, 1'b1);
      op(3'h1, a, 1'b1);
      op(3'h0, 26'h70, 1'b0);
      op(3'h4, 26'h0, 1'b0);
      chk({16'h0, rd}, 32'h60);
      chk({31'h0, flashBusy}, 32'h1);
      wait_ready;
      // both page halves, then a bare address falls back to the first half
      for (int h = 0; h < 2; h++)
      begin
         a = 26'($random(seed));
         op(3'h0, 26'(h), 1'b0);
         op(3'h1, a, 1'b0);
         for (int k = 0; k < 3; k++)
         begin
            op(3'h4, 26'h0, 1'b0);
            chk({16'h0, rd}, col_word(h[0], a[7:0], k));
         end
      end
      op(3'h1, a, 1'b0);
      op(3'h4, 26'h0, 1'b0);
      chk({16'h0, rd}, col_word(1'b0, a[7:0], 0));
      // two-plane erase on neighbouring blocks, then plane status
      ab = addr_bytes(a);
      op(3'h0, 26'h60, 1'b0);
      op(3'h2, a, 1'b0);
      chk({8'h0, dev.addrB[0], dev.addrB[1], dev.addrB[2]}, {8'h0, ab[23:0]});
      op(3'h0, 26'h60, 1'b0);
      op(3'h2, a ^ 26'h4000, 1'b0);
      op(3'h0, 26'hd0, 1'b0);
      op(3'h0, 26'h71, 1'b0);
      op(3'h4, 26'h0, 1'b0);
      chk({16'h0, rd}, 32'h60);
      wait_ready;
      op(3'h0, 26'h71, 1'b0);
      op(3'h4, 26'h0, 1'b0);
      chk({16'h0, rd}, 32'he0);
      // frozen clock enable: a waiting request must not be taken
      clkEn = 1'b0;
      reqValid = 1'b1;
      reqOp = 3'h0;
      reqData = 26'h70;
      repeat (5) @(negedge clk_sys);
      chk({28'h0, reqReady, writeStrobe_n, rspValid, cmdLatch}, 32'hc);
      reqValid = 1'b0;
      clkEn = 1'b1;
      @(negedge clk_sys);
      // defined codes other than 10 and d0 pass, random undefined ones are refused
      for (int i = 0; i < 12; i++)
         op(3'h0, {18'h0, codes[i]}, 1'b0);
      repeat (6)
      begin
         code = 8'($random(seed));
         if (code inside {codes})
            code = 8'h02;
         op(3'h0, {18'h0, code}, 1'b1);
      end
      wrap_up;
   end
endmodule : nfc_host_tb
`default_nettype wire
